//--- rtl/fpcm_defs.svh
// constants of the floating-point context and mode control block
`ifndef FPCM_DEFS_SVH
`define FPCM_DEFS_SVH
`define FPCM_ADDR_CTRL 4'h0
`define FPCM_ADDR_MODE 4'h1
`define FPCM_ADDR_STAT 4'h2
`define FPCM_ADDR_MASK 4'h3
`define FPCM_ADDR_CTX 4'h4
`define FPCM_CTRL_EN_BIT 0
`define FPCM_CTRL_STK_LO 1
`define FPCM_CTRL_STK_HI 2
`define FPCM_MODE_FZ_BIT 0
`define FPCM_MODE_AHP_BIT 1
`define FPCM_MODE_DN_BIT 2
`define FPCM_MODE_RM_LO 3
`define FPCM_MODE_RM_HI 4
`define FPCM_STK_RESET 2'h2
`define FPCM_RM_RESET 2'h0
`define FPCM_FRAME_BASIC 5'h08
`define FPCM_FRAME_FULL 5'h1A
`define FPCM_EXC_W 6
`define FPCM_CTX_W 16
`endif

//--- rtl/fpcm_pkg.sv
// types of the floating-point context and mode control block
package fpcm_pkg;
  typedef enum logic [1:0] {
    FPCM_STK_NONE = 2'h0,
    FPCM_STK_FULL = 2'h1,
    FPCM_STK_LAZY = 2'h2
  } fpcm_stk_t;
  typedef enum logic [1:0] {
    FPCM_RM_NEAREST = 2'h0,
    FPCM_RM_POS_INF = 2'h1,
    FPCM_RM_NEG_INF = 2'h2,
    FPCM_RM_ZERO = 2'h3
  } fpcm_rm_t;
  typedef enum logic [3:0] {
    FPCM_ST_IDLE = 4'h1,
    FPCM_ST_RESERVED = 4'h2,
    FPCM_ST_SAVED = 4'h4,
    FPCM_ST_LEGACY = 4'h8
  } fpcm_state_t;
endpackage : fpcm_pkg

//--- rtl/fpcm_irq.sv
// sticky exception status with mask and level interrupt
`timescale 1ns/100ps
`include "fpcm_defs.svh"
module fpcm_irq (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`FPCM_EXC_W-1:0] event_set,
  input wire logic [`FPCM_EXC_W-1:0] clear_ones,
  input wire logic mask_we,
  input wire logic [`FPCM_EXC_W-1:0] mask_wdata,
  output logic [`FPCM_EXC_W-1:0] status,
  output logic [`FPCM_EXC_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [`FPCM_EXC_W-1:0] status_reg;
    logic [`FPCM_EXC_W-1:0] mask_reg;
    logic irq_reg;
  } fpcm_irq_state_t;
  fpcm_irq_state_t s_reg;
  fpcm_irq_state_t s_next;
  logic [`FPCM_EXC_W-1:0] st_new;
  always_comb
  begin
    s_next = s_reg;
    // set wins over clear
    st_new = (s_reg.status_reg & ~clear_ones) | event_set; // [RULE15]
    s_next.status_reg = st_new;
    if (mask_we)
    begin
      s_next.mask_reg = mask_wdata;
    end
    s_next.irq_reg = |(st_new & s_next.mask_reg); // [RULE15]
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  assign status = s_reg.status_reg;
  assign mask = s_reg.mask_reg;
  assign irq = s_reg.irq_reg;
  AST_IRQ_LEVEL: assert property ( // [RULE15]
    @(posedge clk) disable iff (reset)
    (|(status & mask)) == irq)
    else $error("interrupt level disagrees with masked status");
  AST_STICKY: assert property ( // [RULE15]
    @(posedge clk) disable iff (reset)
    (|event_set) |=> ((status & $past(event_set)) == $past(event_set)))
    else $error("exception event not captured");
endmodule : fpcm_irq

//--- rtl/fpcm_ctrl.sv
// floating-point enable, mode settings and context stacking control
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "fpcm_defs.svh"
// Functional notes
// RULE1 - fp instruction while disabled is blocked, usage fault raised instead
// RULE2 - software enables the unit before any fp operation
// RULE3 - flush-to-zero off gives full IEEE; on treats near-zero as zero
// RULE4 - software sets modes before first fp instruction, else defaults
// RULE5 - half precision IEEE by default, or alternative wider format
// RULE6 - NaNs propagate by default; default-NaN mode returns default NaN
// RULE7 - rounding nearest by default, or plus, minus infinity, or zero
// RULE8 - lazy: entry reserves space, context written at handler's first fp op
// RULE9 - lazy: return restores context only if it was written
// RULE10 - full stacking: entry writes context, return restores it
// RULE11 - stacking off: entry saves no s0-s15 context
// RULE12 - frame is 8 words without fp context, 26 words with it
// RULE13 - unit disabled after reset
// RULE14 - stacking policy resets to lazy
// RULE15 - six fp exceptions each raise an individually enabled interrupt
// RULE16 - settings are writable fields with reset defaults
module fpcm_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic fp_instr_req,
  input wire logic exc_entry,
  input wire logic exc_return,
  input wire logic [`FPCM_EXC_W-1:0] fp_exc_flags,
  output logic fp_instr_grant,
  output logic no_coprocessor_usage_fault,
  output logic flush_zero_on,
  output logic half_format_alt,
  output logic nan_default_mode,
  output logic [1:0] round_mode,
  output logic [4:0] frame_words,
  output logic ctx_save_pulse,
  output logic ctx_restore_pulse,
  output logic irq
);
  typedef struct packed {
    logic en_reg;
    fpcm_pkg::fpcm_stk_t stk_reg;
    logic fz_reg;
    logic ahp_reg;
    logic dn_reg;
    fpcm_pkg::fpcm_rm_t rm_reg;
    fpcm_pkg::fpcm_state_t ctx_reg;
    logic grant_reg;
    logic fault_reg;
    logic [4:0] frame_reg;
    logic save_reg;
    logic restore_reg;
    logic [31:0] rdata_reg;
    logic [`FPCM_CTX_W-1:0] saves_reg;
  } fpcm_state_all_t;
  fpcm_state_all_t s_reg;
  fpcm_state_all_t s_next;
  logic [`FPCM_EXC_W-1:0] st;
  logic [`FPCM_EXC_W-1:0] mk;
  logic [`FPCM_EXC_W-1:0] clr;
  logic mask_we;
  logic irq_w;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  assign clr = (wr_stb && hit(addr, `FPCM_ADDR_STAT)) ?
    wdata[`FPCM_EXC_W-1:0] : '0;
  assign mask_we = wr_stb && hit(addr, `FPCM_ADDR_MASK);

  fpcm_irq u_irq (
    .clk(clk),
    .reset(reset),
    .event_set(fp_exc_flags & {`FPCM_EXC_W{s_reg.en_reg}}),
    .clear_ones(clr),
    .mask_we(mask_we),
    .mask_wdata(wdata[`FPCM_EXC_W-1:0]),
    .status(st),
    .mask(mk),
    .irq(irq_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    s_next.save_reg = 1'b0;
    s_next.restore_reg = 1'b0;
    s_next.grant_reg = 1'b0;
    s_next.fault_reg = 1'b0;
    s_next.rdata_reg = 32'h0000_0000;
    // register writes; new settings apply to later instructions
    if (wr_stb)
    begin
      if (hit(addr, `FPCM_ADDR_CTRL))
      begin
        s_next.en_reg = wdata[`FPCM_CTRL_EN_BIT]; // [RULE16]
        if (wdata[`FPCM_CTRL_STK_HI:`FPCM_CTRL_STK_LO] != 2'h3)
        begin
          s_next.stk_reg = fpcm_pkg::fpcm_stk_t'(
            wdata[`FPCM_CTRL_STK_HI:`FPCM_CTRL_STK_LO]); // [RULE16]
        end
      end
      if (hit(addr, `FPCM_ADDR_MODE))
      begin
        s_next.fz_reg = wdata[`FPCM_MODE_FZ_BIT]; // [RULE3]
        s_next.ahp_reg = wdata[`FPCM_MODE_AHP_BIT]; // [RULE5]
        s_next.dn_reg = wdata[`FPCM_MODE_DN_BIT]; // [RULE6]
        s_next.rm_reg = fpcm_pkg::fpcm_rm_t'(
          wdata[`FPCM_MODE_RM_HI:`FPCM_MODE_RM_LO]); // [RULE7]
      end
    end
    // instruction gate
    if (fp_instr_req)
    begin
      if (s_reg.en_reg)
      begin
        s_next.grant_reg = 1'b1;
      end
      else
      begin
        s_next.fault_reg = 1'b1; // [RULE1]
      end
    end
    // context stacking sequence
    unique case (s_reg.ctx_reg)
      fpcm_pkg::FPCM_ST_IDLE:
      begin
        if (exc_entry)
        begin
          unique case (s_reg.stk_reg)
            fpcm_pkg::FPCM_STK_LAZY:
            begin
              s_next.ctx_reg = fpcm_pkg::FPCM_ST_RESERVED; // [RULE8]
              s_next.frame_reg = `FPCM_FRAME_FULL; // [RULE12]
            end
            fpcm_pkg::FPCM_STK_FULL:
            begin
              s_next.ctx_reg = fpcm_pkg::FPCM_ST_SAVED; // [RULE10]
              s_next.frame_reg = `FPCM_FRAME_FULL; // [RULE12]
              s_next.save_reg = 1'b1;
              s_next.saves_reg = s_reg.saves_reg + 16'h0001;
            end
            default:
            begin
              s_next.ctx_reg = fpcm_pkg::FPCM_ST_LEGACY; // [RULE11]
              s_next.frame_reg = `FPCM_FRAME_BASIC; // [RULE12]
            end
          endcase
        end
      end
      fpcm_pkg::FPCM_ST_RESERVED:
      begin
        if (exc_return)
        begin
          s_next.ctx_reg = fpcm_pkg::FPCM_ST_IDLE; // [RULE9]
        end
        else if (fp_instr_req && s_reg.en_reg)
        begin
          s_next.ctx_reg = fpcm_pkg::FPCM_ST_SAVED; // [RULE8]
          s_next.save_reg = 1'b1;
          s_next.saves_reg = s_reg.saves_reg + 16'h0001;
        end
      end
      fpcm_pkg::FPCM_ST_SAVED:
      begin
        if (exc_return)
        begin
          s_next.ctx_reg = fpcm_pkg::FPCM_ST_IDLE;
          s_next.restore_reg = 1'b1; // [RULE9] [RULE10]
        end
      end
      fpcm_pkg::FPCM_ST_LEGACY:
      begin
        if (exc_return)
        begin
          s_next.ctx_reg = fpcm_pkg::FPCM_ST_IDLE; // [RULE11]
        end
      end
      default:
      begin
        s_next.ctx_reg = fpcm_pkg::FPCM_ST_IDLE;
      end
    endcase
    // register reads, data one cycle later
    if (rd_stb)
    begin
      if (hit(addr, `FPCM_ADDR_CTRL))
      begin
        s_next.rdata_reg = {29'h0000_0000, s_reg.stk_reg, s_reg.en_reg};
      end
      else if (hit(addr, `FPCM_ADDR_MODE))
      begin
        s_next.rdata_reg = {27'h0000_0000, s_reg.rm_reg, s_reg.dn_reg,
          s_reg.ahp_reg, s_reg.fz_reg};
      end
      else if (hit(addr, `FPCM_ADDR_STAT))
      begin
        s_next.rdata_reg = {26'h0000_000, st};
      end
      else if (hit(addr, `FPCM_ADDR_MASK))
      begin
        s_next.rdata_reg = {26'h0000_000, mk};
      end
      else if (hit(addr, `FPCM_ADDR_CTX))
      begin
        s_next.rdata_reg = {s_reg.saves_reg, 7'h00, s_reg.frame_reg,
          s_reg.ctx_reg};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg.en_reg <= 1'b0; // [RULE13]
      s_reg.stk_reg <= fpcm_pkg::fpcm_stk_t'(`FPCM_STK_RESET); // [RULE14]
      s_reg.fz_reg <= 1'b0;
      s_reg.ahp_reg <= 1'b0;
      s_reg.dn_reg <= 1'b0;
      s_reg.rm_reg <= fpcm_pkg::fpcm_rm_t'(`FPCM_RM_RESET); // [RULE16]
      s_reg.ctx_reg <= fpcm_pkg::FPCM_ST_IDLE;
      s_reg.grant_reg <= 1'b0;
      s_reg.fault_reg <= 1'b0;
      s_reg.frame_reg <= `FPCM_FRAME_BASIC;
      s_reg.save_reg <= 1'b0;
      s_reg.restore_reg <= 1'b0;
      s_reg.rdata_reg <= 32'h0000_0000;
      s_reg.saves_reg <= 16'h0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata_reg;
  assign fp_instr_grant = s_reg.grant_reg;
  assign no_coprocessor_usage_fault = s_reg.fault_reg;
  assign flush_zero_on = s_reg.fz_reg;
  assign half_format_alt = s_reg.ahp_reg;
  assign nan_default_mode = s_reg.dn_reg;
  assign round_mode = s_reg.rm_reg;
  assign frame_words = s_reg.frame_reg;
  assign ctx_save_pulse = s_reg.save_reg;
  assign ctx_restore_pulse = s_reg.restore_reg;
  assign irq = irq_w;

  ////////////////////////////////////////////////////////////////////////////
  AST_NO_COPROCESSOR_USAGE_FAULT: assert property ( // [RULE1]
    @(posedge clk) disable iff (reset)
    fp_instr_req && !s_reg.en_reg |=> no_coprocessor_usage_fault
    && !fp_instr_grant)
    else $error("disabled unit did not fault");
  AST_GRANT: assert property ( // [RULE1]
    @(posedge clk) disable iff (reset)
    fp_instr_req && s_reg.en_reg |=> fp_instr_grant
    && !no_coprocessor_usage_fault)
    else $error("enabled unit did not grant");
  AST_LAZY_ENTRY: assert property ( // [RULE8]
    @(posedge clk) disable iff (reset)
    exc_entry && s_reg.ctx_reg == fpcm_pkg::FPCM_ST_IDLE
    && s_reg.stk_reg == fpcm_pkg::FPCM_STK_LAZY
    |=> !ctx_save_pulse && frame_words == 5'h1A)
    else $error("lazy entry wrote context or wrong frame");
  AST_LAZY_SAVE: assert property ( // [RULE8]
    @(posedge clk) disable iff (reset)
    s_reg.ctx_reg == fpcm_pkg::FPCM_ST_RESERVED && fp_instr_req
    && s_reg.en_reg && !exc_return |=> ctx_save_pulse)
    else $error("lazy save missing at first fp op");
  AST_LAZY_RET: assert property ( // [RULE9]
    @(posedge clk) disable iff (reset)
    s_reg.ctx_reg == fpcm_pkg::FPCM_ST_RESERVED && exc_return
    |=> !ctx_restore_pulse)
    else $error("restore without prior save");
  AST_FULL: assert property ( // [RULE10]
    @(posedge clk) disable iff (reset)
    exc_entry && s_reg.ctx_reg == fpcm_pkg::FPCM_ST_IDLE
    && s_reg.stk_reg == fpcm_pkg::FPCM_STK_FULL
    |=> ctx_save_pulse && frame_words == 5'h1A)
    else $error("full stacking did not save context");
  AST_RESTORE: assert property ( // [RULE9] [RULE10]
    @(posedge clk) disable iff (reset)
    s_reg.ctx_reg == fpcm_pkg::FPCM_ST_SAVED && exc_return
    |=> ctx_restore_pulse)
    else $error("saved context not restored");
  AST_NONE: assert property ( // [RULE11] [RULE12]
    @(posedge clk) disable iff (reset)
    exc_entry && s_reg.ctx_reg == fpcm_pkg::FPCM_ST_IDLE
    && s_reg.stk_reg == fpcm_pkg::FPCM_STK_NONE
    |=> !ctx_save_pulse && frame_words == 5'h08)
    else $error("stacking off still saved context");
  AST_RESET_DEF: assert property ( // [RULE13] [RULE14]
    @(posedge clk) disable iff (reset)
    $past(reset) |-> !s_reg.en_reg
    && s_reg.stk_reg == fpcm_pkg::FPCM_STK_LAZY)
    else $error("wrong defaults after reset");
  AST_MODE_WR: assert property ( // [RULE7] [RULE3]
    @(posedge clk) disable iff (reset)
    wr_stb && addr == 4'h1 |=> round_mode == $past(wdata[4:3])
    && flush_zero_on == $past(wdata[0]))
    else $error("mode write not applied");
  COV_LAZY_SAVE: cover property (@(posedge clk) disable iff (reset)
    ctx_save_pulse && s_reg.stk_reg == fpcm_pkg::FPCM_STK_LAZY);
  COV_RESTORE: cover property (@(posedge clk) disable iff (reset)
    ctx_restore_pulse);
  COV_FAULT: cover property (@(posedge clk) disable iff (reset)
    no_coprocessor_usage_fault);
  COV_IRQ: cover property (@(posedge clk) disable iff (reset) irq);
endmodule : fpcm_ctrl

//--- tb/fpcm_core_model.sv
// core-side partner: fp issue, exception entry/return, exception flags
`timescale 1ns/100ps
`include "fpcm_defs.svh"
module fpcm_core_model (
  input wire logic clk,
  output logic fp_instr_req,
  output logic exc_entry,
  output logic exc_return,
  output logic [`FPCM_EXC_W-1:0] fp_exc_flags
);
  initial
  begin
    fp_instr_req = 1'b0;
    exc_entry = 1'b0;
    exc_return = 1'b0;
    fp_exc_flags = 6'h00;
  end
  // idle cycles first model a slow core; pulse lasts one cycle
  task automatic pulse(input int sel, input int gap, input logic [5:0] f);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    case (sel)
      0: fp_instr_req <= 1'b1;
      1: exc_entry <= 1'b1;
      2: exc_return <= 1'b1;
      default: fp_exc_flags <= f;
    endcase
    @(posedge clk);
    fp_instr_req <= 1'b0;
    exc_entry <= 1'b0;
    exc_return <= 1'b0;
    fp_exc_flags <= 6'h00;
  endtask : pulse
endmodule : fpcm_core_model

//--- tb/test_fp_context_and_mode_control.sv
// self-checking bench of the fp context and mode control block
`timescale 1ns/100ps
`include "fpcm_defs.svh"
module test_fp_context_and_mode_control;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic fp_instr_req, exc_entry, exc_return;
  logic [5:0] fp_exc_flags;
  logic fp_instr_grant, no_coprocessor_usage_fault, irq;
  logic flush_zero_on, half_format_alt, nan_default_mode;
  logic ctx_save_pulse, ctx_restore_pulse;
  logic [1:0] round_mode;
  logic [4:0] frame_words;
  logic [31:0] d;
  int num_errors = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  fpcm_ctrl u_fpcm_ctrl (.clk, .reset, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .fp_instr_req, .exc_entry, .exc_return, .fp_exc_flags,
    .fp_instr_grant, .no_coprocessor_usage_fault, .flush_zero_on,
    .half_format_alt, .nan_default_mode, .round_mode, .frame_words,
    .ctx_save_pulse, .ctx_restore_pulse, .irq);
  fpcm_core_model u_fpcm_core_model (.clk, .fp_instr_req, .exc_entry,
    .exc_return, .fp_exc_flags);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t %s", $time, m);
      num_errors++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata & m, e, "read data");
  endtask : rdchk
  // core request, then grant/fault/save/restore in the answer cycle
  task automatic op(input int sel, gap, input logic [3:0] e);
    u_fpcm_core_model.pulse(sel, gap, 6'h00);
    #1;
    chk({28'h0, fp_instr_grant, no_coprocessor_usage_fault,
      ctx_save_pulse, ctx_restore_pulse}, {28'h0, e}, "core answer");
  endtask : op
  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 6 && irq !== v; n++) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, v}, "irq level");
  endtask : wait_irq
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({22'h0, fp_instr_grant, no_coprocessor_usage_fault, flush_zero_on,
      half_format_alt, nan_default_mode, round_mode, ctx_save_pulse,
      ctx_restore_pulse, irq}, 32'h0, "outputs after reset");
    chk({27'h0, frame_words}, 32'h08, "frame after reset");
    wr(4'hF, 32'hFFFFFFFF);
    rdchk(`FPCM_ADDR_CTRL, 32'hFFFFFFFF, 32'h4);
    rdchk(`FPCM_ADDR_MODE, 32'hFFFFFFFF, 32'h0);
    rdchk(`FPCM_ADDR_CTX, 32'h1FF, 32'h81);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0, "read data held too long");
    rdchk(4'hF, 32'hFFFFFFFF, 32'h0);
    op(0, 0, 4'b0100);
    $display("reset and disabled test done");
  endtask : t_reset
  task automatic t_modes;
    logic [4:0] m;
    wr(`FPCM_ADDR_CTRL, 32'h5);
    for (int r = 0; r < 4; r++)
    begin
      m = {r[1:0], 3'(r + 1)};
      wr(`FPCM_ADDR_MODE, {27'h0, m});
      rdchk(`FPCM_ADDR_MODE, 32'h1F, {27'h0, m});
      chk({27'h0, round_mode, nan_default_mode, half_format_alt,
        flush_zero_on}, {27'h0, m}, "mode outputs");
      op(0, r, 4'b1000);
    end
    wr(`FPCM_ADDR_MODE, 32'h0);
    $display("mode test done");
  endtask : t_modes
  task automatic t_stack;
    logic [1:0] k[3] = '{2'h1, 2'h0, 2'h2};
    for (int i = 0; i < 3; i++)
    begin
      wr(`FPCM_ADDR_CTRL, {29'h0, k[i], 1'b1});
      op(1, i, {2'b00, k[i] == 2'h1, 1'b0});
      chk({27'h0, frame_words}, k[i] == 2'h0 ? 32'h08 : 32'h1A,
        "frame size");
      op(0, i, {2'b10, k[i] == 2'h2, 1'b0});
      op(2, 0, {3'b000, k[i] != 2'h0});
    end
    op(1, 0, 4'b0000);
    rdchk(`FPCM_ADDR_CTX, 32'h1FF, 32'h1A2);
    op(2, 2, 4'b0000);
    wr(`FPCM_ADDR_CTRL, 32'h7);
    rdchk(`FPCM_ADDR_CTRL, 32'h7, 32'h5);
    wr(`FPCM_ADDR_CTRL, 32'h4);
    op(1, 0, 4'b0000);
    op(0, 0, 4'b0100);
    op(2, 0, 4'b0000);
    $display("stacking test done");
  endtask : t_stack
  task automatic t_irq;
    wr(`FPCM_ADDR_CTRL, 32'h5);
    wr(`FPCM_ADDR_MASK, 32'h2);
    u_fpcm_core_model.pulse(3, 0, 6'h01);
    rdchk(`FPCM_ADDR_STAT, 32'h3F, 32'h01);
    chk({31'h0, irq}, 32'h0, "masked event");
    u_fpcm_core_model.pulse(3, 0, 6'h02);
    wait_irq(1'b1);
    wr(`FPCM_ADDR_STAT, 32'h2);
    wait_irq(1'b0);
    rdchk(`FPCM_ADDR_STAT, 32'h3F, 32'h01);
    wr(`FPCM_ADDR_MASK, 32'h3F);
    wait_irq(1'b1);
    u_fpcm_core_model.pulse(3, 1, 6'h3E);
    rdchk(`FPCM_ADDR_STAT, 32'h3F, 32'h3F);
    wr(`FPCM_ADDR_STAT, 32'h3F);
    wait_irq(1'b0);
    // event and clear in one cycle: the event must stay
    fork
      wr(`FPCM_ADDR_STAT, 32'h04);
      u_fpcm_core_model.pulse(3, 0, 6'h04);
    join
    rdchk(`FPCM_ADDR_STAT, 32'h3F, 32'h04);
    wr(`FPCM_ADDR_STAT, 32'h3F);
    wr(`FPCM_ADDR_CTRL, 32'h4);
    u_fpcm_core_model.pulse(3, 0, 6'h3F);
    rdchk(`FPCM_ADDR_STAT, 32'h3F, 32'h00);
    $display("interrupt test done");
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_modes();
    t_stack();
    t_irq();
    stop_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : test_fp_context_and_mode_control
